// ==== verilog/smbus_sensor_client_port.sv ====
// two-wire client port: framing, addressing, pointer/write commands, alert response
// assumes open-drain pads outside; clk_link free running, phase unrelated to clk_sys
`timescale 1ns/1ps
module smbus_sensor_client_port #(
  parameter int VARIANT = smbus_client_pkg::VARIANT_RESISTOR,
  parameter int POWERUP_CYCLES = smbus_client_pkg::POWERUP_CYC,
  parameter int TIMEOUT_CYCLES = smbus_client_pkg::TIMEOUT_CYC
) (
  // clocks and reset
  input wire logic clk_sys,
  input wire logic clk_link,
  input wire logic rst,
  // two-wire bus pins
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  // over-temperature and address-select pin
  input wire logic [2:0] addr_sel_code,
  input wire logic therm_request,
  output logic opendrain_output_pin_out,
  output logic opendrain_output_pin_oe,
  // alert pin
  input wire logic status_active,
  input wire logic mask_all,
  input wire logic alert_mask_clr,
  output logic alert_pin_out,
  output logic alert_pin_oe,
  output logic alert_mask,
  // configuration and status
  input wire logic timeout_en,
  output logic ready,
  output logic [6:0] own_addr,
  // register file side
  input wire logic [7:0] reg_rd_data,
  output logic [7:0] reg_index,
  output smbus_client_pkg::reg_cmd_t reg_wr,
  output logic reg_wr_valid
);

  localparam int PU_W = $clog2(POWERUP_CYCLES + 1);
  localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);

  if (VARIANT < 0 || VARIANT > 2 || POWERUP_CYCLES < 1 || TIMEOUT_CYCLES < 2) begin : g_bad
    $error("smbus_sensor_client_port: unsupported parameter value");
  end

  // ------------------------------------------------------------------
  // power-up wait and address capture (system domain)
  // ------------------------------------------------------------------
  logic [PU_W-1:0] pu_cnt_ff;
  logic [PU_W-1:0] nxt_pu_cnt;
  logic ready_ff;
  logic [6:0] own_addr_ff;
  logic [2:0] addr_code_s;
  wire pu_done = (pu_cnt_ff == PU_W'(POWERUP_CYCLES));
  wire [6:0] res_addr = (addr_code_s < smbus_client_pkg::RES_CODES) ?
    smbus_client_pkg::RES_ADDR_TABLE[addr_code_s] : smbus_client_pkg::FIXED_ADDR_A;
  wire [6:0] decoded_addr = (VARIANT == smbus_client_pkg::VARIANT_RESISTOR) ? res_addr :
    (VARIANT == smbus_client_pkg::VARIANT_FIXED_A) ? smbus_client_pkg::FIXED_ADDR_A :
    smbus_client_pkg::FIXED_ADDR_B;

  assign nxt_pu_cnt = pu_done ? pu_cnt_ff : pu_cnt_ff + 1'b1;

  sync_filter #(.WIDTH(3)) u_addr_sync (
    .clk(clk_sys),
    .rst(rst),
    .d(addr_sel_code),
    .q(addr_code_s)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pu_cnt_ff <= '0;
      ready_ff <= 1'b0;
      own_addr_ff <= '0;
    end else begin
      pu_cnt_ff <= nxt_pu_cnt;
      ready_ff <= pu_done;
      if (pu_done && !ready_ff) begin
        own_addr_ff <= decoded_addr;
      end
    end
  end

  // ------------------------------------------------------------------
  // clock-low timeout (system domain)
  // ------------------------------------------------------------------
  logic scl_s;
  logic [TO_W-1:0] to_cnt_ff;
  logic [TO_W-1:0] nxt_to_cnt;
  logic bus_tmo_ff;
  wire to_run = timeout_en & ~scl_s;
  wire to_hit = (to_cnt_ff == TO_W'(TIMEOUT_CYCLES));

  assign nxt_to_cnt = !to_run ? '0 : (to_hit ? to_cnt_ff : to_cnt_ff + 1'b1);

  sync_filter #(.WIDTH(1)) u_sys_scl (
    .clk(clk_sys),
    .rst(rst),
    .d(serial_clock_pin),
    .q(scl_s)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      to_cnt_ff <= '0;
      bus_tmo_ff <= 1'b0;
    end else begin
      to_cnt_ff <= nxt_to_cnt;
      bus_tmo_ff <= to_run & to_hit;
    end
  end

  a_timeout_cause: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(bus_tmo_ff) |-> $past(timeout_en) && !$past(scl_s))
    else $error("timeout fired without enable or with clock high");

  // ------------------------------------------------------------------
  // commands from the link and alert masking (system domain)
  // ------------------------------------------------------------------
  logic cmd_tgl_ff;
  logic ara_tgl_ff;
  smbus_client_pkg::reg_cmd_t cmd_ff;
  logic [1:0] evt_s;
  logic [1:0] evt_prev_ff;
  logic [7:0] reg_index_ff;
  smbus_client_pkg::reg_cmd_t reg_wr_ff;
  logic reg_wr_valid_ff;
  logic alert_mask_ff;
  logic alert_pend_ff;
  logic alert_oe_ff;
  logic ot_oe_ff;
  wire cmd_evt = evt_s[1] ^ evt_prev_ff[1];
  wire ara_evt = evt_s[0] ^ evt_prev_ff[0];
  wire nxt_alert_mask = ara_evt | (alert_mask_ff & ~alert_mask_clr);
  wire alert_pending = status_active & ~alert_mask_ff;
  wire nxt_alert_oe = alert_pending & ~mask_all & ready_ff;

  sync_filter #(.WIDTH(2)) u_evt_sync (
    .clk(clk_sys),
    .rst(rst),
    .d({cmd_tgl_ff, ara_tgl_ff}),
    .q(evt_s)
  );

  // payload has been stable for several cycles when its toggle arrives
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      evt_prev_ff <= '0;
      reg_index_ff <= '0;
      reg_wr_ff <= '0;
      reg_wr_valid_ff <= 1'b0;
      alert_mask_ff <= 1'b0;
      alert_pend_ff <= 1'b0;
      alert_oe_ff <= 1'b0;
      ot_oe_ff <= 1'b0;
    end else begin
      evt_prev_ff <= evt_s;
      reg_index_ff <= cmd_evt ? cmd_ff.index : reg_index_ff;
      reg_wr_ff <= cmd_evt ? cmd_ff : reg_wr_ff;
      reg_wr_valid_ff <= cmd_evt & cmd_ff.is_write;
      alert_mask_ff <= nxt_alert_mask;
      alert_pend_ff <= alert_pending;
      alert_oe_ff <= nxt_alert_oe;
      ot_oe_ff <= therm_request & ready_ff;
    end
  end

  // open-drain: only ever pull low
  assign alert_pin_out = 1'b0;
  assign alert_pin_oe = alert_oe_ff;
  assign opendrain_output_pin_out = 1'b0;
  assign opendrain_output_pin_oe = ot_oe_ff;
  assign alert_mask = alert_mask_ff;
  assign ready = ready_ff;
  assign own_addr = own_addr_ff;
  assign reg_index = reg_index_ff;
  assign reg_wr = reg_wr_ff;
  assign reg_wr_valid = reg_wr_valid_ff;

  a_suppress_alert: assert property (@(posedge clk_sys) disable iff (rst)
    mask_all |=> !alert_pin_oe)
    else $error("alert driven while suppressed");

  a_ara_sets_mask: assert property (@(posedge clk_sys) disable iff (rst)
    ara_evt |=> alert_mask_ff ##1 !alert_pin_oe)
    else $error("won alert response did not mask alert");

  a_unmask_realert: assert property (@(posedge clk_sys) disable iff (rst)
    (alert_mask_ff && alert_mask_clr && !ara_evt) ##1
    (status_active && !mask_all && ready_ff && !ara_evt) |=> alert_pin_oe)
    else $error("alert not reasserted after unmask");

  a_ptr_stable: assert property (@(posedge clk_sys) disable iff (rst)
    !cmd_evt |=> $stable(reg_index_ff) && !reg_wr_valid_ff)
    else $error("pointer or write changed without a command");

  // ------------------------------------------------------------------
  // crossing into the link domain
  // ------------------------------------------------------------------
  logic [17:0] to_link;
  logic [1:0] pins_l;

  sync_filter #(.WIDTH(18)) u_to_link (
    .clk(clk_link),
    .rst(rst),
    .d({ready_ff, alert_pend_ff, bus_tmo_ff, own_addr_ff, reg_rd_data}),
    .q(to_link)
  );

  sync_filter #(.WIDTH(2)) u_link_pins (
    .clk(clk_link),
    .rst(rst),
    .d({serial_clock_pin, serial_data_pin_in}),
    .q(pins_l)
  );

  wire ready_l = to_link[17];
  wire alert_l = to_link[16];
  wire tmo_l = to_link[15];
  wire [6:0] own_l = to_link[14:8];
  wire [7:0] rd_l = to_link[7:0];
  wire scl_l = pins_l[1];
  wire sda_l = pins_l[0];

  // ------------------------------------------------------------------
  // bus engine (link domain)
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_IDX, ST_IDX_ACK,
    ST_DATA, ST_DATA_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
  } link_state_t;

  link_state_t st_ff, nxt_st;
  logic scl_prev_ff, sda_prev_ff;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh;
  logic [7:0] tx_ff, nxt_tx;
  logic [7:0] idx_ff, nxt_idx;
  logic [7:0] data_ff, nxt_data;
  logic drive_ff, nxt_drive;
  logic ara_ff, nxt_ara;
  logic have_idx_ff, nxt_have_idx;
  logic have_data_ff, nxt_have_data;
  logic nxt_cmd_tgl, nxt_ara_tgl;
  smbus_client_pkg::reg_cmd_t nxt_cmd;

  // edge-driven only, so a stretched clock low is waited out unless the enabled timeout expires and resets the engine
  wire start_det = scl_l & scl_prev_ff & sda_prev_ff & ~sda_l;
  wire stop_det = scl_l & scl_prev_ff & ~sda_prev_ff & sda_l;
  wire scl_rise = scl_l & ~scl_prev_ff;
  wire scl_fall = ~scl_l & scl_prev_ff;
  wire byte_done = scl_fall && (cnt_ff == smbus_client_pkg::BYTE_BITS);
  wire addr_hit = (sh_ff[7:1] == own_l);
  wire ara_hit = (sh_ff[7:1] == smbus_client_pkg::ARA_ADDR) & sh_ff[0] & alert_l;
  wire [7:0] tx_byte = ara_ff ? {own_l, 1'b1} : rd_l;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_tx = tx_ff;
    nxt_idx = idx_ff;
    nxt_data = data_ff;
    nxt_drive = drive_ff;
    nxt_ara = ara_ff;
    nxt_have_idx = have_idx_ff;
    nxt_have_data = have_data_ff;
    nxt_cmd = cmd_ff;
    nxt_cmd_tgl = cmd_tgl_ff;
    nxt_ara_tgl = ara_tgl_ff;
    if (tmo_l || !ready_l) begin
      nxt_st = ST_IDLE;
      nxt_drive = 1'b0;
      nxt_ara = 1'b0;
      nxt_have_idx = 1'b0;
      nxt_have_data = 1'b0;
    end else if (start_det || stop_det) begin
      // repeated start after an index loads pointer; stop commits send or write
      if (have_idx_ff && (stop_det || !have_data_ff)) begin
        nxt_cmd = '{is_write: have_data_ff & stop_det, index: idx_ff, data: data_ff};
        nxt_cmd_tgl = ~cmd_tgl_ff;
      end
      nxt_st = start_det ? ST_ADDR : ST_IDLE;
      nxt_cnt = '0;
      nxt_drive = 1'b0;
      nxt_ara = 1'b0;
      nxt_have_idx = 1'b0;
      nxt_have_data = 1'b0;
    end else begin
      case (st_ff)
        ST_ADDR, ST_IDX, ST_DATA: begin
          if (scl_rise) begin
            nxt_sh = {sh_ff[6:0], sda_l};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (byte_done) begin
            nxt_cnt = '0;
            nxt_st = ST_IGNORE;
            if (st_ff == ST_ADDR && (addr_hit || ara_hit)) begin
              nxt_st = ST_ADDR_ACK;
              nxt_drive = 1'b1;
              nxt_ara = ara_hit;
            end else if (st_ff == ST_IDX) begin
              nxt_st = ST_IDX_ACK;
              nxt_drive = 1'b1;
              nxt_idx = sh_ff;
              nxt_have_idx = 1'b1;
            end else if (st_ff == ST_DATA && !have_data_ff) begin
              nxt_st = ST_DATA_ACK;
              nxt_drive = 1'b1;
              nxt_data = sh_ff;
              nxt_have_data = 1'b1;
            end else if (st_ff == ST_DATA) begin
              nxt_have_idx = 1'b0;
              nxt_have_data = 1'b0;
            end
          end
        end
        ST_ADDR_ACK, ST_IDX_ACK, ST_DATA_ACK: begin
          if (scl_fall) begin
            nxt_drive = 1'b0;
            nxt_st = (st_ff == ST_ADDR_ACK) ? ST_IDX : ST_DATA;
            if (st_ff == ST_ADDR_ACK && (ara_ff || sh_ff[0])) begin
              nxt_st = ST_TX;
              nxt_tx = tx_byte;
              nxt_drive = ~tx_byte[7];
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            nxt_cnt = cnt_ff + 4'h1;
            if (tx_ff[7] && !sda_l) begin
              nxt_st = ST_IGNORE;
            end
          end else if (byte_done) begin
            nxt_cnt = '0;
            nxt_drive = 1'b0;
            nxt_st = ST_TX_ACK;
            if (ara_ff) begin
              nxt_ara_tgl = ~ara_tgl_ff;
            end
          end else if (scl_fall) begin
            nxt_tx = {tx_ff[6:0], 1'b0};
            nxt_drive = ~tx_ff[6];
          end
        end
        ST_TX_ACK: begin
          if (scl_rise && (sda_l || ara_ff)) begin
            nxt_st = ST_IGNORE;
          end else if (scl_fall) begin
            nxt_st = ST_TX;
            nxt_tx = rd_l;
            nxt_drive = ~rd_l[7];
          end
        end
        ST_IDLE, ST_IGNORE: begin
          nxt_st = st_ff;
        end
        default: begin
          nxt_st = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      st_ff <= ST_IDLE;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      cnt_ff <= '0;
      sh_ff <= '0;
      tx_ff <= '0;
      idx_ff <= '0;
      data_ff <= '0;
      drive_ff <= 1'b0;
      ara_ff <= 1'b0;
      have_idx_ff <= 1'b0;
      have_data_ff <= 1'b0;
      cmd_ff <= '0;
      cmd_tgl_ff <= 1'b0;
      ara_tgl_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      scl_prev_ff <= scl_l;
      sda_prev_ff <= sda_l;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      tx_ff <= nxt_tx;
      idx_ff <= nxt_idx;
      data_ff <= nxt_data;
      drive_ff <= nxt_drive;
      ara_ff <= nxt_ara;
      have_idx_ff <= nxt_have_idx;
      have_data_ff <= nxt_have_data;
      cmd_ff <= nxt_cmd;
      cmd_tgl_ff <= nxt_cmd_tgl;
      ara_tgl_ff <= nxt_ara_tgl;
    end
  end

  assign serial_data_pin_out = 1'b0;
  assign serial_data_pin_oe = drive_ff;

  a_start_to_addr: assert property (@(posedge clk_link) disable iff (rst)
    (start_det && ready_l && !tmo_l) |=> (st_ff == ST_ADDR) && !serial_data_pin_oe)
    else $error("start did not open address phase");

  a_stop_to_idle: assert property (@(posedge clk_link) disable iff (rst)
    stop_det |=> (st_ff == ST_IDLE) && !serial_data_pin_oe)
    else $error("stop did not reset the engine");

  a_ack_low: assert property (@(posedge clk_link) disable iff (rst)
    (st_ff inside {ST_ADDR_ACK, ST_IDX_ACK, ST_DATA_ACK}) |-> serial_data_pin_oe)
    else $error("acknowledge slot not driven low");

  a_ignore_quiet: assert property (@(posedge clk_link) disable iff (rst)
    (st_ff == ST_IGNORE) |-> !serial_data_pin_oe)
    else $error("data driven in ignored transfer");

  a_msb_first: assert property (@(posedge clk_link) disable iff (rst)
    (st_ff == ST_TX) |-> (serial_data_pin_oe == !tx_ff[7]))
    else $error("transmit bit is not the shift msb");

  a_powerup_quiet: assert property (@(posedge clk_link) disable iff (rst)
    !ready_l |=> (st_ff == ST_IDLE) && !serial_data_pin_oe)
    else $error("bus answered before address decode finished");

endmodule

// ==== verilog/smbus_client_pkg.sv ====
// constants and carrier types of the two-wire sensor client port
// assumes a 20 MHz system clock; shared by the client port and the testbench
package smbus_client_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int POWERUP_MS = 15;
  localparam int TIMEOUT_MS = 30;
  localparam int POWERUP_CYC = POWERUP_MS * (SYS_CLK_HZ / 1000);
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (SYS_CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam logic [6:0] FIXED_ADDR_A = 7'h4c;
  localparam logic [6:0] FIXED_ADDR_B = 7'h18;
  // strap code 0..5: 4.7k, 6.8k, 10k, 15k, 22k, 33k
  localparam logic [5:0][6:0] RES_ADDR_TABLE = {7'h3c, 7'h1c, 7'h6c, 7'h4c, 7'h5c, 7'h7c};
  localparam logic [2:0] RES_CODES = 3'h6;
  localparam int VARIANT_RESISTOR = 0;
  localparam int VARIANT_FIXED_A = 1;
  localparam int VARIANT_FIXED_B = 2;

  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic is_write;
    logic [7:0] index;
    logic [7:0] data;
  } reg_cmd_t;

endpackage

// ==== verilog/sync_filter.sv ====
// three-stage synchroniser with agreement filter
// assumes asynchronous inputs; output changes once stages two and three agree
`timescale 1ns/1ps
module sync_filter #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] q_ff;
  logic [WIDTH-1:0] nxt_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("sync_filter: WIDTH must be at least 1");
  end

  assign nxt_q = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & q_ff);
  assign q = q_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff <= '0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end

endmodule

// ==== testbench/smbus_host_model.sv ====
// two-wire host model: start, stop, byte write and read with ack
// assumes open-drain wiring in the bench; paces its bus from clk_sys
`timescale 1ns/1ps
module smbus_host_model (
  // clock
  input wire logic clk_sys,
  // bus
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  int hseed = 32'hc396;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // random phase length, stretches the clock
  task automatic wq();
    repeat (13 + $unsigned($random(hseed)) % 8) @(posedge clk_sys);
    #2;
  endtask

  task automatic bit_x(input logic b, output logic r);
    sda_low = !b;
    wq();
    scl = 1'b1;
    wq();
    r = sda;
    wq();
    scl = 1'b0;
    wq();
  endtask

  task automatic start();
    sda_low = 1'b0;
    wq();
    scl = 1'b1;
    wq();
    sda_low = 1'b1;
    wq();
    scl = 1'b0;
    wq();
  endtask

  task automatic stop();
    sda_low = 1'b1;
    wq();
    scl = 1'b1;
    wq();
    sda_low = 1'b0;
    wq();
  endtask

  task automatic tx(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(v[i], r);
    bit_x(1'b1, ack);
  endtask

  // low bits of drv pull the line against the device
  task automatic rx(input logic ack, input logic [7:0] drv, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(drv[i], v[i]);
    bit_x(ack, r);
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench for the two-wire sensor client port
// assumes the host model beside it; open-drain lines pulled up here
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int PU = 20;
  localparam int TO = 50;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst = 1'b1;
  logic scl, host_low, sda;
  logic [2:0] code = 3'h0;
  logic therm_request = 1'b0;
  logic status_active = 1'b0;
  logic mask_all = 1'b0;
  logic alert_mask_clr = 1'b0;
  logic timeout_en = 1'b0;
  logic [7:0] reg_rd_data;
  logic sdo, sda_oe, od_out, od_oe, al_out, al_oe, alert_mask, ready;
  logic [6:0] own_addr, own, own_fix;
  logic [7:0] reg_index, idx, dat, rb, rb2;
  smbus_client_pkg::reg_cmd_t reg_wr;
  logic reg_wr_valid;
  logic a0, a1, a2;
  int seed = 32'hc396;
  int fail_count = 0;
  int checks_done = 0;
  int n_wr = 0;
  int w0;

  assign sda = !(host_low | sda_oe);
  assign reg_rd_data = reg_index ^ 8'ha5;

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    #7;
    forever #24 clk_link = ~clk_link;
  end
  always @(negedge clk_sys) begin
    if (reg_wr_valid === 1'b1) n_wr++;
  end

  smbus_sensor_client_port #(
    .VARIANT(smbus_client_pkg::VARIANT_RESISTOR),
    .POWERUP_CYCLES(PU),
    .TIMEOUT_CYCLES(TO)
  ) u_dut (
    .clk_sys(clk_sys), .clk_link(clk_link), .rst(rst),
    .serial_clock_pin(scl), .serial_data_pin_in(sda),
    .serial_data_pin_out(sdo), .serial_data_pin_oe(sda_oe),
    .addr_sel_code(code), .therm_request(therm_request),
    .opendrain_output_pin_out(od_out), .opendrain_output_pin_oe(od_oe),
    .status_active(status_active), .mask_all(mask_all), .alert_mask_clr(alert_mask_clr),
    .alert_pin_out(al_out), .alert_pin_oe(al_oe), .alert_mask(alert_mask),
    .timeout_en(timeout_en), .ready(ready), .own_addr(own_addr),
    .reg_rd_data(reg_rd_data), .reg_index(reg_index),
    .reg_wr(reg_wr), .reg_wr_valid(reg_wr_valid)
  );

  smbus_host_model u_host (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(host_low));

  // fixed-address variant: only its address is observed, its data pin stays off the bus
  smbus_sensor_client_port #(
    .VARIANT(smbus_client_pkg::VARIANT_FIXED_B),
    .POWERUP_CYCLES(PU),
    .TIMEOUT_CYCLES(TO)
  ) u_dut_fix (
    .clk_sys(clk_sys), .clk_link(clk_link), .rst(rst),
    .serial_clock_pin(scl), .serial_data_pin_in(sda),
    .serial_data_pin_out(), .serial_data_pin_oe(),
    .addr_sel_code(code), .therm_request(therm_request),
    .opendrain_output_pin_out(), .opendrain_output_pin_oe(),
    .status_active(status_active), .mask_all(mask_all), .alert_mask_clr(alert_mask_clr),
    .alert_pin_out(), .alert_pin_oe(), .alert_mask(),
    .timeout_en(timeout_en), .ready(), .own_addr(own_fix),
    .reg_rd_data(reg_rd_data), .reg_index(),
    .reg_wr(), .reg_wr_valid()
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [6:0] exp_addr(input logic [2:0] c);
    case (c)
      3'h0: return 7'h7c;
      3'h1: return 7'h5c;
      3'h2: return 7'h4c;
      3'h3: return 7'h6c;
      3'h4: return 7'h1c;
      default: return 7'h3c;
    endcase
  endfunction

  task automatic chk(input logic [16:0] g, input logic [16:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    therm_request = 1'b1;
    tick(12);
    rst = 1'b0;
    tick(PU / 2);
    chk({ready, od_oe, alert_mask, reg_index}, 17'h0, "powerup idle");
    for (int i = 0; i < 40 && ready !== 1'b1; i++) tick(1);
    tick(20);
    chk({ready, od_oe}, 2'b11, "ready");
    therm_request = 1'b0;
  endtask

  task automatic addr_w(input logic [6:0] a, input logic [7:0] i);
    u_host.start();
    u_host.tx({a, 1'b0}, a0);
    u_host.tx(i, a1);
  endtask

  initial begin
    #(60000 * 50);
    fail_count++;
    end_sim();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    for (int c = 0; c < 7; c++) begin
      code = (c < 6) ? 3'(c) : 3'($unsigned($random(seed)) % 6);
      do_reset();
      chk(own_addr, exp_addr(code), "strap");
    end
    own = exp_addr(code);
    chk(own_fix, 7'h18, "fixed");
    $display("test strap done");
    for (int k = 0; k < 3; k++) begin
      idx = (k == 0) ? 8'hff : 8'($random(seed));
      dat = 8'($random(seed));
      w0 = n_wr;
      addr_w(own, idx);
      u_host.tx(dat, a2);
      u_host.stop();
      tick(20);
      chk({a0, a1, a2}, 3'h0, "write ack");
      chk(17'(n_wr - w0), 17'h1, "write pulse");
      chk(reg_wr, {1'b1, idx, dat}, "write cmd");
      chk(reg_index, idx, "write ptr");
    end
    $display("test write done");
    idx = 8'($random(seed));
    w0 = n_wr;
    addr_w(own, idx);
    u_host.stop();
    tick(20);
    chk({reg_wr.is_write, reg_index}, {1'b0, idx}, "send ptr");
    chk(17'(n_wr - w0), 17'h0, "send write");
    u_host.start();
    u_host.tx({own, 1'b1}, a0);
    u_host.rx(1'b0, 8'hff, rb);
    u_host.rx(1'b1, 8'hff, rb2);
    u_host.stop();
    tick(20);
    chk({a0, rb, rb2}, {1'b0, idx ^ 8'ha5, idx ^ 8'ha5}, "receive");
    chk(reg_index, idx, "receive ptr");
    $display("test send receive done");
    idx = 8'($random(seed));
    addr_w(own, idx);
    u_host.start();
    u_host.tx({own, 1'b1}, a2);
    u_host.rx(1'b1, 8'hff, rb);
    u_host.stop();
    tick(20);
    chk({a0, a1, a2, rb}, {3'h0, idx ^ 8'ha5}, "read");
    chk(reg_index, idx, "read ptr");
    w0 = n_wr;
    addr_w(own ^ 7'h01, 8'($random(seed)));
    u_host.tx(8'h5a, a2);
    u_host.stop();
    tick(20);
    chk({a0, a1, a2, reg_index}, {3'h7, idx}, "foreign");
    chk(17'(n_wr - w0), 17'h0, "foreign write");
    $display("test read foreign done");
    status_active = 1'b1;
    tick(3);
    chk(al_oe, 1'b1, "alert on");
    for (int j = 0; j < 3; j++) begin
      u_host.start();
      u_host.tx({7'h0c, 1'b1}, a0);
      u_host.rx(1'b1, (j == 0) ? 8'hfe : 8'hff, rb);
      u_host.stop();
      tick(20);
      chk({a0, rb[7:1], alert_mask, al_oe},
          {j == 2, (j == 2) ? 7'h7f : own, j != 0, j == 0}, "ara");
    end
    chk({sdo, al_out, od_out}, 3'h0, "low only");
    alert_mask_clr = 1'b1;
    tick(1);
    alert_mask_clr = 1'b0;
    tick(3);
    chk({alert_mask, al_oe}, 2'b01, "unmask");
    mask_all = 1'b1;
    tick(3);
    chk(al_oe, 1'b0, "suppress");
    mask_all = 1'b0;
    status_active = 1'b0;
    $display("test alert done");
    dat = {own, 1'b0};
    u_host.start();
    for (int i = 7; i >= 0; i--) u_host.bit_x(dat[i], a1);
    tick(10);
    chk(sda_oe, 1'b1, "ack held");
    tick(TO + 20);
    chk(sda_oe, 1'b1, "timeout off");
    timeout_en = 1'b1;
    tick(TO + 20);
    chk(sda_oe, 1'b0, "timeout");
    u_host.stop();
    timeout_en = 1'b0;
    tick(20);
    $display("test timeout done");
    end_sim();
  end
endmodule
